// ===== logic/dbcsm_pkg.sv
package dbcsm_pkg;
   // ---------------------------------------------
   // timing and geometry
   // ---------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int NUM_BANKS = 4;
   localparam int CNT_W = 8;
   localparam int PRECHARGE_TIME_NS = 15;
   localparam int ACTIVATE_TO_ACCESS_TIME_NS = 15;
   localparam int REFRESH_CYCLE_TIME_NS = 75;
   localparam int MODE_SET_TIME_NS = 10;
   localparam int BURST_CYCLES = 2;
   localparam logic [CNT_W-1:0] PRECHARGE_CYC =
      CNT_W'((PRECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] ACT_ACCESS_CYC =
      CNT_W'((ACTIVATE_TO_ACCESS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] REFRESH_CYC =
      CNT_W'((REFRESH_CYCLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] MODE_SET_CYC =
      CNT_W'((MODE_SET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] BURST_CYC = CNT_W'(BURST_CYCLES);

   // ---------------------------------------------
   // commands and states
   // ---------------------------------------------
   typedef enum logic [2:0] {
      CMD_NOP, CMD_ACTIVE, CMD_READ, CMD_WRITE, CMD_PRECHARGE,
      CMD_BURST_STOP, CMD_REFRESH, CMD_MODE_SET
   } dbcsm_cmd_t;

   typedef enum logic [3:0] {
      BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_READ, BK_WRITE,
      BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING
   } dbcsm_bank_state_t;

   typedef struct packed {
      logic chipSelect_n;
      logic rowStrobe_n;
      logic colStrobe_n;
      logic writeEnable_n;
      logic autoPrechargeAddressBit;
      logic bankSelectBit1;
      logic bankSelectBit0;
   } dbcsm_cmd_bus_t;

   typedef struct packed {
      dbcsm_bank_state_t state;
      logic [CNT_W-1:0] count;
   } dbcsm_bank_t;
endpackage

// ===== logic/dbcsm_timer.sv
// down counter for one timed state; done pulses when it expires
module dbcsm_timer #(
   parameter int W = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [W-1:0] loadValue,
   output logic busy,
   output logic done
);
   typedef struct packed {
      logic [W-1:0] count;
      logic done;
   } dbcsm_tmr_t;
   dbcsm_tmr_t s_r;
   dbcsm_tmr_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (load) begin
         s_nxt.count = loadValue;
      end else if (s_r.count != '0) begin
         s_nxt.count = s_r.count - W'(1);
         s_nxt.done = (s_r.count == W'(1));
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign busy = (s_r.count != '0);
   assign done = s_r.done;

   timer_expires_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (load && loadValue == W'(1)) ##1 !load |=> done)
      else $error("timer did not expire after loaded count");
endmodule

// ===== logic/dbcsm_bank_fsm.sv
// Summary of operation
// - deselect or no-op changes nothing; timed operations keep running
// - active in idle opens the row and starts row activating
// - read or write in row active starts a burst
// - precharge in row active or a plain burst closes the row and starts precharging
// - read during a plain read restarts the read burst
// - precharge during a plain read truncates it and starts precharging
// - burst terminate ends the most recent read burst if it is a plain read, any bank
// - read during a plain write interrupts it; controller masks leftover data
// - precharge during a plain write truncates it; controller masks data
// - commands act only with clock enable high now and before, after exit time
// - idle only after precharge time; active only after activate time, no burst
// - precharging lasts the precharge time then the bank is idle
// - row activating lasts the activate-to-access time then row active
// - read or write with auto precharge keeps the bank busy until precharged
// - auto refresh blocks all commands for refresh cycle time, then all idle
// - mode register set blocks all commands for mode-set time, then all idle
// - precharge all blocks commands for precharge time, then all idle
// - read and write transitions apply with and without auto precharge
// - address bit chooses single-bank or all-bank precharge
module dbcsm_bank_fsm #(
   parameter int EXIT_CYCLES = 200
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clockEnable,
   input wire logic selfRefreshExit,
   input wire dbcsm_pkg::dbcsm_cmd_bus_t cmdBus,
   output logic [4*dbcsm_pkg::NUM_BANKS-1:0] bankStates,
   output logic [dbcsm_pkg::NUM_BANKS-1:0] bankIdle,
   output logic deviceBusy,
   output logic illegalCmd
);
   localparam int NB = dbcsm_pkg::NUM_BANKS;
   localparam int CW = dbcsm_pkg::CNT_W;

   // ---------------------------------------------
   // registered state: input synchronisers, exit counter, banks, outputs
   // ---------------------------------------------
   typedef struct packed {
      dbcsm_pkg::dbcsm_cmd_bus_t cmdMeta;
      dbcsm_pkg::dbcsm_cmd_bus_t cmdSync;
      logic [1:0] ckeMeta;
      logic [1:0] ckeSync;
      logic ckePrev;
      logic [15:0] exitCount;
      dbcsm_pkg::dbcsm_bank_t [NB-1:0] bank;
      logic [1:0] lastReadBank;
      logic lastReadValid;
      logic [NB-1:0] idleOut;
      logic [4*NB-1:0] stateOut;
      logic busyOut;
      logic illegalOut;
   } dbcsm_state_t;

   dbcsm_state_t s_r;
   dbcsm_state_t s_nxt;

   logic globalLoad;
   logic [CW-1:0] globalValue;
   logic globalBusy;
   logic globalDone;

   function automatic dbcsm_pkg::dbcsm_cmd_t decode(input dbcsm_pkg::dbcsm_cmd_bus_t c);
      logic [2:0] rcw;
      rcw = {c.rowStrobe_n, c.colStrobe_n, c.writeEnable_n};
      if (c.chipSelect_n) begin
         return dbcsm_pkg::CMD_NOP;
      end
      case (rcw)
         3'h3: return dbcsm_pkg::CMD_ACTIVE;
         3'h5: return dbcsm_pkg::CMD_READ;
         3'h4: return dbcsm_pkg::CMD_WRITE;
         3'h2: return dbcsm_pkg::CMD_PRECHARGE;
         3'h6: return dbcsm_pkg::CMD_BURST_STOP;
         3'h1: return dbcsm_pkg::CMD_REFRESH;
         3'h0: return dbcsm_pkg::CMD_MODE_SET;
         default: return dbcsm_pkg::CMD_NOP;
      endcase
   endfunction

   function automatic logic isPlainBurst(input dbcsm_pkg::dbcsm_bank_state_t st);
      return (st == dbcsm_pkg::BK_READ) || (st == dbcsm_pkg::BK_WRITE);
   endfunction

   // ---------------------------------------------
   // device-wide timer for refresh, mode set, precharge all
   // ---------------------------------------------
   dbcsm_timer #(
      .W(CW)
   ) globalTimer (
      .mclk(mclk),
      .rst_n(rst_n),
      .load(globalLoad),
      .loadValue(globalValue),
      .busy(globalBusy),
      .done(globalDone)
   );

   dbcsm_pkg::dbcsm_cmd_t cmd;
   logic cmdValid;
   logic [1:0] tgt;
   logic allIdle;

   always_comb begin
      cmd = decode(s_r.cmdSync);
      tgt = {s_r.cmdSync.bankSelectBit1, s_r.cmdSync.bankSelectBit0};
      // commands count only with clock enable high on both edges, exit time met
      cmdValid = s_r.ckeSync[1] && s_r.ckePrev && (s_r.exitCount == 16'h0000) && !globalBusy;
      allIdle = 1'b1;
      for (int i = 0; i < NB; i++) begin
         if (s_r.bank[i].state != dbcsm_pkg::BK_IDLE) begin
            allIdle = 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // next state
   // ---------------------------------------------
   always_comb begin
      s_nxt = s_r;
      globalLoad = 1'b0;
      globalValue = '0;
      s_nxt.cmdMeta = cmdBus;
      s_nxt.cmdSync = s_r.cmdMeta;
      s_nxt.ckeMeta = {s_r.ckeMeta[0], clockEnable};
      s_nxt.ckeSync = {s_r.ckeSync[0], selfRefreshExit};
      s_nxt.ckeSync[1] = s_r.ckeMeta[1];
      s_nxt.ckeSync[0] = s_r.ckeMeta[0];
      s_nxt.ckeMeta = {clockEnable, selfRefreshExit};
      s_nxt.ckePrev = s_r.ckeSync[1];
      s_nxt.illegalOut = 1'b0;
      if (s_r.ckeSync[0]) begin
         s_nxt.exitCount = 16'(EXIT_CYCLES);
      end else if (s_r.exitCount != 16'h0000) begin
         s_nxt.exitCount = s_r.exitCount - 16'h0001;
      end

      // per-bank timed states run regardless of the command
      for (int i = 0; i < NB; i++) begin
         if (s_r.bank[i].count > '0) begin
            s_nxt.bank[i].count = s_r.bank[i].count - CW'(1);
         end
         if (s_r.bank[i].count == CW'(1)) begin
            case (s_r.bank[i].state)
               dbcsm_pkg::BK_ACTIVATING: s_nxt.bank[i].state = dbcsm_pkg::BK_ACTIVE;
               dbcsm_pkg::BK_PRECHARGING: s_nxt.bank[i].state = dbcsm_pkg::BK_IDLE;
               dbcsm_pkg::BK_READ, dbcsm_pkg::BK_WRITE: s_nxt.bank[i].state = dbcsm_pkg::BK_ACTIVE;
               dbcsm_pkg::BK_READ_AP, dbcsm_pkg::BK_WRITE_AP: begin
                  s_nxt.bank[i].state = dbcsm_pkg::BK_PRECHARGING;
                  s_nxt.bank[i].count = dbcsm_pkg::PRECHARGE_CYC;
               end
               default: s_nxt.bank[i].state = s_r.bank[i].state;
            endcase
         end
      end
      if (globalDone) begin
         for (int i = 0; i < NB; i++) begin
            s_nxt.bank[i] = '{state: dbcsm_pkg::BK_IDLE, count: '0};
         end
      end

      if (cmdValid) begin
         case (cmd)
            dbcsm_pkg::CMD_NOP: s_nxt.illegalOut = 1'b0;
            dbcsm_pkg::CMD_ACTIVE: begin
               if (s_r.bank[tgt].state == dbcsm_pkg::BK_IDLE) begin
                  s_nxt.bank[tgt] = '{state: dbcsm_pkg::BK_ACTIVATING, count: dbcsm_pkg::ACT_ACCESS_CYC};
               end else begin
                  s_nxt.illegalOut = 1'b1;
               end
            end
            dbcsm_pkg::CMD_READ, dbcsm_pkg::CMD_WRITE: begin
               // ok from row active read restart write interrupt
               if (s_r.bank[tgt].state == dbcsm_pkg::BK_ACTIVE || isPlainBurst(s_r.bank[tgt].state)) begin
                  if (cmd == dbcsm_pkg::CMD_READ) begin
                     s_nxt.bank[tgt].state = s_r.cmdSync.autoPrechargeAddressBit ?
                        dbcsm_pkg::BK_READ_AP : dbcsm_pkg::BK_READ;
                     s_nxt.lastReadBank = tgt;
                     s_nxt.lastReadValid = 1'b1;
                  end else begin
                     s_nxt.bank[tgt].state = s_r.cmdSync.autoPrechargeAddressBit ?
                        dbcsm_pkg::BK_WRITE_AP : dbcsm_pkg::BK_WRITE;
                  end
                  s_nxt.bank[tgt].count = dbcsm_pkg::BURST_CYC;
                  if (s_r.bank[tgt].state == dbcsm_pkg::BK_READ && cmd == dbcsm_pkg::CMD_WRITE) begin
                     s_nxt.bank[tgt] = s_r.bank[tgt];
                     s_nxt.illegalOut = 1'b1;
                  end
               end else begin
                  s_nxt.illegalOut = 1'b1;
               end
            end
            dbcsm_pkg::CMD_PRECHARGE: begin
               if (s_r.cmdSync.autoPrechargeAddressBit) begin
                  globalLoad = 1'b1;
                  globalValue = dbcsm_pkg::PRECHARGE_CYC;
                  for (int i = 0; i < NB; i++) begin
                     s_nxt.bank[i] = '{state: dbcsm_pkg::BK_PRECHARGING, count: '0};
                  end
               end else if (s_r.bank[tgt].state == dbcsm_pkg::BK_ACTIVE
                            || isPlainBurst(s_r.bank[tgt].state)) begin
                  s_nxt.bank[tgt] = '{state: dbcsm_pkg::BK_PRECHARGING, count: dbcsm_pkg::PRECHARGE_CYC};
                  if (s_r.lastReadBank == tgt) begin
                     s_nxt.lastReadValid = 1'b0;
                  end
               end else if (s_r.bank[tgt].state != dbcsm_pkg::BK_IDLE) begin
                  s_nxt.illegalOut = 1'b1;
               end
            end
            dbcsm_pkg::CMD_BURST_STOP: begin
               if (s_r.lastReadValid && s_r.bank[s_r.lastReadBank].state == dbcsm_pkg::BK_READ) begin
                  s_nxt.bank[s_r.lastReadBank] = '{state: dbcsm_pkg::BK_ACTIVE, count: '0};
               end
               s_nxt.lastReadValid = 1'b0;
            end
            dbcsm_pkg::CMD_REFRESH, dbcsm_pkg::CMD_MODE_SET: begin
               if (allIdle) begin
                  globalLoad = 1'b1;
                  globalValue = (cmd == dbcsm_pkg::CMD_REFRESH) ?
                     dbcsm_pkg::REFRESH_CYC : dbcsm_pkg::MODE_SET_CYC;
               end else begin
                  s_nxt.illegalOut = 1'b1;
               end
            end
            default: s_nxt.illegalOut = 1'b1;
         endcase
      end else if (cmd != dbcsm_pkg::CMD_NOP && s_r.ckeSync[1] && s_r.ckePrev) begin
         s_nxt.illegalOut = 1'b1;
      end

      for (int i = 0; i < NB; i++) begin
         s_nxt.idleOut[i] = (s_nxt.bank[i].state == dbcsm_pkg::BK_IDLE);
         s_nxt.stateOut[4*i +: 4] = s_nxt.bank[i].state;
      end
      s_nxt.busyOut = globalLoad || (globalBusy && !globalDone);
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_r <= '0;
         s_r.exitCount <= 16'h0000;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bankStates = s_r.stateOut;
   assign bankIdle = s_r.idleOut;
   assign deviceBusy = s_r.busyOut;
   assign illegalCmd = s_r.illegalOut;

   // ---------------------------------------------
   // checks
   // ---------------------------------------------
   activate_open_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (cmdValid && cmd == dbcsm_pkg::CMD_ACTIVE && s_r.bank[tgt].state == dbcsm_pkg::BK_IDLE)
      |=> s_r.bank[$past(tgt)].state == dbcsm_pkg::BK_ACTIVATING)
      else $error("active did not start activation");
   activate_done_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_r.bank[0].state == dbcsm_pkg::BK_ACTIVATING && s_r.bank[0].count == CW'(1) && !globalDone)
      |=> s_r.bank[0].state == dbcsm_pkg::BK_ACTIVE)
      else $error("activation did not end in row active");
   precharge_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (s_r.bank[0].state == dbcsm_pkg::BK_PRECHARGING && s_r.bank[0].count == CW'(1))
      |=> s_r.bank[0].state == dbcsm_pkg::BK_IDLE)
      else $error("precharge did not end in idle");
   nop_holds_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (cmd == dbcsm_pkg::CMD_NOP && s_r.bank[1].count == '0 && !globalDone)
      |=> s_r.bank[1].state == $past(s_r.bank[1].state))
      else $error("no-op changed a settled bank");
   cke_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (!s_r.ckePrev && s_r.bank[tgt].state == dbcsm_pkg::BK_IDLE)
      |=> s_r.bank[$past(tgt)].state == dbcsm_pkg::BK_IDLE)
      else $error("command accepted with clock enable low");
   refresh_block_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (cmdValid && cmd == dbcsm_pkg::CMD_REFRESH && allIdle) |=> !cmdValid [*3])
      else $error("command accepted during refresh");
   ap_busy_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (cmdValid && cmd == dbcsm_pkg::CMD_READ && s_r.cmdSync.autoPrechargeAddressBit
       && s_r.bank[tgt].state == dbcsm_pkg::BK_ACTIVE) |=> !bankIdle[$past(tgt)])
      else $error("auto precharge bank reported idle");
   pre_all_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (cmdValid && cmd == dbcsm_pkg::CMD_PRECHARGE && s_r.cmdSync.autoPrechargeAddressBit)
      |=> ##1 (deviceBusy && bankIdle == '0))
      else $error("precharge all not holding banks");
   burst_stop_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (cmdValid && cmd == dbcsm_pkg::CMD_BURST_STOP && s_r.lastReadValid
       && s_r.bank[s_r.lastReadBank].state == dbcsm_pkg::BK_READ)
      |=> s_r.bank[$past(s_r.lastReadBank)].state == dbcsm_pkg::BK_ACTIVE)
      else $error("burst terminate did not end the read");
   write_break_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (cmdValid && cmd == dbcsm_pkg::CMD_READ && !s_r.cmdSync.autoPrechargeAddressBit
       && s_r.bank[tgt].state == dbcsm_pkg::BK_WRITE)
      |=> s_r.bank[$past(tgt)].state == dbcsm_pkg::BK_READ)
      else $error("read did not interrupt the write");
endmodule

// ===== tb/dbcsm_ctl_model.sv
// --------------------------------------------
// memory controller model on the command pins
// --------------------------------------------
module dbcsm_ctl_model (
   input wire logic mclk,
   output dbcsm_pkg::dbcsm_cmd_bus_t cmdBus
);
   timeunit 1ns;
   timeprecision 1ps;

   logic junk = 1'b0;
   logic pendReq = 1'b0;
   logic pendAck = 1'b0;
   logic [6:0] pendBus = 7'h40;
   dbcsm_pkg::dbcsm_cmd_bus_t busR = 7'h40;

   assign cmdBus = busR;

   // deselected cycles: unselected lines toggle so no stale command shows
   always @(negedge mclk) begin
      junk <= ~junk;
      pendAck <= pendReq;
      busR <= (pendReq != pendAck) ? pendBus : {1'b1, {6{junk}}};
   end

   // one command for one cycle, deselect after; caller keeps legal order
   task automatic issue(input logic [3:0] code, input logic ap, input logic [1:0] bank);
      @(posedge mclk);
      pendBus = {code, ap, bank};
      pendReq = ~pendReq;
      @(negedge mclk);
      #1;
   endtask
endmodule

// ===== tb/ddr_bank_command_state_machine_test.sv
module ddr_bank_command_state_machine_test;
   timeunit 1ns;
   timeprecision 1ps;

   // --------------------------------------------
   // signals and codes
   // --------------------------------------------
   localparam int EXIT_N = 4;
   localparam logic [3:0] C_ACT = 4'h3;
   localparam logic [3:0] C_RD = 4'h5;
   localparam logic [3:0] C_WR = 4'h4;
   localparam logic [3:0] C_PRE = 4'h2;
   localparam logic [3:0] C_BST = 4'h6;
   localparam logic [3:0] C_REF = 4'h1;
   localparam logic [3:0] C_MRS = 4'h0;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic clockEnable = 1'b1;
   logic selfRefreshExit = 1'b0;
   dbcsm_pkg::dbcsm_cmd_bus_t cmdBus;
   logic [15:0] bankStates;
   logic [3:0] bankIdle;
   logic deviceBusy;
   logic illegalCmd;
   int miscompares = 0;
   int checks = 0;
   int illegals = 0;
   int n0;
   logic [1:0] b;
   logic [31:0] rngState = 32'h00009A97;

   always #12.5 mclk = ~mclk;
   always @(negedge mclk) if (illegalCmd === 1'b1) illegals++;

   dbcsm_bank_fsm #(.EXIT_CYCLES(EXIT_N)) i_dut (.mclk(mclk), .rst_n(rst_n), .clockEnable(clockEnable),
      .selfRefreshExit(selfRefreshExit), .cmdBus(cmdBus), .bankStates(bankStates), .bankIdle(bankIdle),
      .deviceBusy(deviceBusy), .illegalCmd(illegalCmd));
   dbcsm_ctl_model i_ctl (.mclk(mclk), .cmdBus(cmdBus));

   // --------------------------------------------
   // helpers
   // --------------------------------------------
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic [1:0] rndBank();
      rngState = xorshift(rngState);
      return rngState[1:0];
   endfunction

   function automatic dbcsm_pkg::dbcsm_bank_state_t burstState(input logic [3:0] code, input logic ap);
      if (code == C_RD)
         return ap ? dbcsm_pkg::BK_READ_AP : dbcsm_pkg::BK_READ;
      return ap ? dbcsm_pkg::BK_WRITE_AP : dbcsm_pkg::BK_WRITE;
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // polls for a registered state under a bounded count
   task automatic waitSt(input logic [1:0] bk, input dbcsm_pkg::dbcsm_bank_state_t st);
      int n;
      n = 0;
      while (bankStates[4*bk +: 4] !== st && n < 12) begin
         @(negedge mclk);
         n++;
      end
      check(bankStates[4*bk +: 4], st);
   endtask

   task automatic openRow(input logic [1:0] bk);
      i_ctl.issue(C_ACT, 1'b0, bk);
      waitSt(bk, dbcsm_pkg::BK_ACTIVATING);
      waitSt(bk, dbcsm_pkg::BK_ACTIVE);
   endtask

   task automatic summarize();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial begin
      #(25 * 6000);
      miscompares++;
      $display("[ERR] t=%0t watchdog expired", $time);
      summarize();
   end

   // --------------------------------------------
   // tests
   // --------------------------------------------
   initial begin
      idle(10);
      rst_n = 1'b1;
      idle(4);
      check(bankIdle, 4'hF);
      check(bankStates, 16'h0000);
      $display("test reset done");
      b = rndBank();
      n0 = illegals;
      i_ctl.issue(C_RD, 1'b0, b);
      idle(6);
      check(illegals, n0 + 1);
      check(bankStates[4*b +: 4], dbcsm_pkg::BK_IDLE);
      openRow(b);
      check(bankIdle[b], 1'b0);
      idle(int'(rndBank()) + 3);
      check(bankStates[4*b +: 4], dbcsm_pkg::BK_ACTIVE);
      n0 = illegals;
      i_ctl.issue(C_RD, 1'b0, b);
      i_ctl.issue(C_RD, 1'b0, b);
      i_ctl.issue(C_BST, 1'b0, b ^ 2'h1);
      idle(1);
      check(bankStates[4*b +: 4], dbcsm_pkg::BK_READ);
      idle(1);
      check(bankStates[4*b +: 4], dbcsm_pkg::BK_READ);
      idle(1);
      check(bankStates[4*b +: 4], dbcsm_pkg::BK_ACTIVE);
      i_ctl.issue(C_RD, 1'b0, b);
      i_ctl.issue(C_PRE, 1'b0, b);
      waitSt(b, dbcsm_pkg::BK_PRECHARGING);
      waitSt(b, dbcsm_pkg::BK_IDLE);
      check(illegals, n0);
      $display("test read flow done");
      openRow(b);
      i_ctl.issue(C_WR, 1'b0, b);
      i_ctl.issue(C_RD, 1'b0, b);
      waitSt(b, dbcsm_pkg::BK_WRITE);
      waitSt(b, dbcsm_pkg::BK_READ);
      i_ctl.issue(C_WR, 1'b0, b);
      i_ctl.issue(C_PRE, 1'b0, b);
      waitSt(b, dbcsm_pkg::BK_WRITE);
      waitSt(b, dbcsm_pkg::BK_PRECHARGING);
      waitSt(b, dbcsm_pkg::BK_IDLE);
      check(illegals, n0);
      openRow(b);
      i_ctl.issue(C_RD, 1'b0, b);
      i_ctl.issue(C_WR, 1'b0, b);
      idle(4);
      check(illegals, n0 + 1);
      i_ctl.issue(C_WR, 1'b0, b);
      i_ctl.issue(C_WR, 1'b0, b);
      idle(2);
      check(bankStates[4*b +: 4], dbcsm_pkg::BK_WRITE);
      idle(2);
      check(bankStates[4*b +: 4], dbcsm_pkg::BK_WRITE);
      i_ctl.issue(C_PRE, 1'b0, b);
      waitSt(b, dbcsm_pkg::BK_IDLE);
      check(illegals, n0 + 1);
      $display("test write flow done");
      for (int k = 0; k < 2; k++) begin
         b = rndBank();
         openRow(b);
         n0 = illegals;
         i_ctl.issue(k == 0 ? C_RD : C_WR, 1'b1, b);
         i_ctl.issue(C_RD, 1'b0, b);
         waitSt(b, burstState(k == 0 ? C_RD : C_WR, 1'b1));
         waitSt(b, dbcsm_pkg::BK_IDLE);
         check(illegals, n0 + 1);
      end
      $display("test auto precharge done");
      b = rndBank();
      openRow(b);
      openRow(b ^ 2'h1);
      i_ctl.issue(C_PRE, 1'b0, b);
      waitSt(b, dbcsm_pkg::BK_IDLE);
      check(bankStates[4*(b^2'h1) +: 4], dbcsm_pkg::BK_ACTIVE);
      openRow(b);
      i_ctl.issue(C_PRE, 1'b1, b ^ 2'h2);
      idle(3);
      check(deviceBusy, 1'b1);
      idle(6);
      check(bankStates, 16'h0000);
      $display("test precharge done");
      n0 = illegals;
      i_ctl.issue(C_REF, 1'b0, rndBank());
      i_ctl.issue(C_ACT, 1'b0, b);
      idle(2);
      check(deviceBusy, 1'b1);
      idle(8);
      check(deviceBusy, 1'b0);
      check(bankIdle, 4'hF);
      check(illegals, n0 + 1);
      i_ctl.issue(C_MRS, 1'b0, rndBank());
      idle(3);
      check(deviceBusy, 1'b1);
      idle(6);
      check(bankIdle, 4'hF);
      $display("test global done");
      clockEnable = 1'b0;
      idle(3);
      i_ctl.issue(C_ACT, 1'b0, b);
      idle(3);
      clockEnable = 1'b1;
      idle(5);
      check(bankStates[4*b +: 4], dbcsm_pkg::BK_IDLE);
      selfRefreshExit = 1'b1;
      idle(1);
      selfRefreshExit = 1'b0;
      i_ctl.issue(C_ACT, 1'b0, b);
      idle(EXIT_N + 6);
      check(bankStates[4*b +: 4], dbcsm_pkg::BK_IDLE);
      openRow(b);
      $display("test clock enable done");
      summarize();
   end
endmodule
